// File: sdr_bank.sv
/*
 * High dedicated data register bank (numbers 200..216) of a servo
 * controller. Host reads and writes through a request struct; the servo
 * core supplies live values and receives the writable limits.
 * Assumes requests are synchronous to clk and last one cycle each.
 */
// What this block does
// - Register 200 holds external encoder count; host may read and write.
// - Register 201 captures encoder count at last external index trigger; RW.
// - Register 203 read-only: lower half third status word, upper half reserved.
// - Registers 204, 205 read-only target acceleration and target velocity.
// - Register 206 closed-loop holding/moving torque, writable torque limit command.
// - Register 207 open-loop holding/moving torque, read and write.
// - Register 208 moving/holding error limits, writable error limit command.
// - Register 209 read-only: direction mask upper, io_state_word lower.
// - Register 210 read-only program buffer size upper, start lower.
// - Kill event writes register 211 with conditions upper, states lower.
// - Kill condition bits stay latched until overwritten.
// - Write of zero to register 211 is accepted and clears it.
// - Register 212 read-only filtered analog inputs one and two.
// - Analog registers readable any time without disturbing the program.
// - Register 213 read-only raw analog inputs three and four.
// - Register 214 read-only drive supply voltage and raw controller temperature.
// - Register 215 read-only processor voltage and driver temperature.
// - Register 216 read-only peak driver voltage and drive calibration.
// - Registers are 32 bits, halves separately addressable.
// - Read-only contents and register 200 refresh once per 120 us servo cycle.
module sdr_bank (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire sdr_pkg::sdr_req_t  req,
    input  wire sdr_pkg::sdr_live_t live,
    output logic                   rvalid,
    output logic [31:0]            rdata,
    output logic [31:0]            ext_enc_count,
    output logic [31:0]            closed_loop_torque,
    output logic [31:0]            open_loop_torque,
    output logic [31:0]            error_limits,
    output logic [31:0]            kill_cause,
    output logic                   servo_tick
);

    sdr_pkg::sdr_state_t st;
    sdr_pkg::sdr_state_t next_st;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [1:0]  en);
        logic [31:0] r;
        r = old;
        if (en[1]) begin
            r[31:sdr_pkg::UPPER_LSB] = wd[31:sdr_pkg::UPPER_LSB];
        end
        if (en[0]) begin
            r[sdr_pkg::LOWER_MSB:0] = wd[sdr_pkg::LOWER_MSB:0];
        end
        return r;
    endfunction

    logic wr_enc;
    logic wr_idx;
    logic wr_kill;
    assign wr_enc  = req.wr && req.addr == sdr_pkg::REG_EXT_ENC;
    assign wr_idx  = req.wr && req.addr == sdr_pkg::REG_EXT_IDX;
    assign wr_kill = req.wr && req.addr == sdr_pkg::REG_KILL;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        // Servo cycle timebase
        if (st.tick_cnt == sdr_pkg::SERVO_CNT_LAST) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = 14'(st.tick_cnt + 14'h0001);
        end
        // Snapshots of core values, taken once per servo cycle
        if (st.tick) begin
            next_st.enc         = live.ext_enc;
            next_st.snap_stat3  = {16'h0000, live.third_status_word};
            next_st.snap_tacc   = live.tacc;
            next_st.snap_tvel   = live.tvel;
            next_st.snap_dir_io = {live.dir_mask, live.io_state_word};
            next_st.snap_pbuf   = {live.pbuf_size, live.pbuf_start};
            next_st.snap_an12   = {live.an1, live.an2};
            next_st.snap_an34   = {live.an3, live.an4};
            next_st.snap_drv_v  = {live.drv_volt, live.cpu_temp};
            next_st.snap_cpu_v  = {live.cpu_volt, live.drv_temp};
            next_st.snap_peak_v = {live.peak_volt, live.drv_cal};
        end
        if (live.idx_trig) begin
            next_st.idx = live.ext_enc;
        end
        // Host writes take priority over servo refresh of the same word; an index trigger wins over a host write to the index capture
        if (wr_enc) begin
            next_st.enc = merge(st.enc, req.wdata, req.half_en);
        end
        if (wr_idx && !live.idx_trig) begin
            next_st.idx = merge(st.idx, req.wdata, req.half_en);
        end
        if (req.wr && req.addr == sdr_pkg::REG_CL_TQ) begin
            next_st.cl_tq = merge(st.cl_tq, req.wdata, req.half_en);
        end
        if (req.wr && req.addr == sdr_pkg::REG_OL_TQ) begin
            next_st.ol_tq = merge(st.ol_tq, req.wdata, req.half_en);
        end
        if (req.wr && req.addr == sdr_pkg::REG_ERRLIM) begin
            next_st.errlim = merge(st.errlim, req.wdata, req.half_en);
        end
        if (wr_kill) begin
            next_st.kill = merge(st.kill, req.wdata, req.half_en);
        end
        // Kill event wins over a simultaneous host clear; otherwise latched
        if (live.kill_evt) begin
            next_st.kill = {live.kill_cond, live.kill_state};
        end
        // Read path; read-only words have no write term at all
        next_st.rvalid = req.rd;
        next_st.rdata  = sdr_pkg::RST_WORD;
        if (req.rd) begin
            case (req.addr)
                sdr_pkg::REG_EXT_ENC: next_st.rdata = st.enc;
                sdr_pkg::REG_EXT_IDX: next_st.rdata = st.idx;
                sdr_pkg::REG_STAT3:   next_st.rdata = st.snap_stat3;
                sdr_pkg::REG_TACC:    next_st.rdata = st.snap_tacc;
                sdr_pkg::REG_TVEL:    next_st.rdata = st.snap_tvel;
                sdr_pkg::REG_CL_TQ:   next_st.rdata = st.cl_tq;
                sdr_pkg::REG_OL_TQ:   next_st.rdata = st.ol_tq;
                sdr_pkg::REG_ERRLIM:  next_st.rdata = st.errlim;
                sdr_pkg::REG_DIR_IO:  next_st.rdata = st.snap_dir_io;
                sdr_pkg::REG_PBUF:    next_st.rdata = st.snap_pbuf;
                sdr_pkg::REG_KILL:    next_st.rdata = st.kill;
                sdr_pkg::REG_AN12:    next_st.rdata = st.snap_an12;
                sdr_pkg::REG_AN34:    next_st.rdata = st.snap_an34;
                sdr_pkg::REG_DRV_V:   next_st.rdata = st.snap_drv_v;
                sdr_pkg::REG_CPU_V:   next_st.rdata = st.snap_cpu_v;
                sdr_pkg::REG_PEAK_V:  next_st.rdata = st.snap_peak_v;
                default:              next_st.rdata = sdr_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rvalid             = st.rvalid;
    assign rdata              = st.rdata;
    assign ext_enc_count      = st.enc;
    assign closed_loop_torque = st.cl_tq;
    assign open_loop_torque   = st.ol_tq;
    assign error_limits       = st.errlim;
    assign kill_cause         = st.kill;
    assign servo_tick         = st.tick;

    // Checks
    property p_tick_period;
        @(posedge clk) disable iff (!rstn)
        st.tick |=> !st.tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("servo tick too frequent");

    property p_kill_capture;
        @(posedge clk) disable iff (!rstn)
        live.kill_evt |=> kill_cause == {$past(live.kill_cond), $past(live.kill_state)};
    endproperty
    a_kill_capture: assert property (p_kill_capture) else $error("kill cause not captured");

    property p_kill_latched;
        @(posedge clk) disable iff (!rstn)
        (!live.kill_evt && !wr_kill) |=> $stable(kill_cause);
    endproperty
    a_kill_latched: assert property (p_kill_latched) else $error("kill cause changed");

    property p_kill_clear;
        @(posedge clk) disable iff (!rstn)
        (wr_kill && !live.kill_evt && req.half_en == sdr_pkg::HALF_BOTH
         && req.wdata == 32'h0000_0000) |=> kill_cause == 32'h0000_0000;
    endproperty
    a_kill_clear: assert property (p_kill_clear) else $error("kill clear lost");

    property p_idx_capture;
        @(posedge clk) disable iff (!rstn)
        live.idx_trig |=> st.idx == $past(live.ext_enc);
    endproperty
    a_idx_capture: assert property (p_idx_capture) else $error("index not captured");

    property p_tq_write;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == sdr_pkg::REG_CL_TQ && req.half_en[0])
        |=> closed_loop_torque[15:0] == $past(req.wdata[15:0]);
    endproperty
    a_tq_write: assert property (p_tq_write) else $error("torque write lost");

    property p_err_write;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == sdr_pkg::REG_ERRLIM && req.half_en == 2'h2)
        |=> error_limits[15:0] == $past(error_limits[15:0]);
    endproperty
    a_err_write: assert property (p_err_write) else $error("lower half disturbed");

    property p_ro_read;
        @(posedge clk) disable iff (!rstn)
        (req.rd && req.addr == sdr_pkg::REG_STAT3) |=> rvalid && rdata[31:16] == 16'h0000;
    endproperty
    a_ro_read: assert property (p_ro_read) else $error("status read wrong");

    property p_rsvd_read;
        @(posedge clk) disable iff (!rstn)
        (req.rd && req.addr == sdr_pkg::REG_RSVD_A) |=> rvalid && rdata == 32'h0000_0000;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved not zero");

    property p_tick_at_wrap;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |-> st.tick_cnt == 14'h0000;
    endproperty
    a_tick_at_wrap: assert property (p_tick_at_wrap) else $error("tick off wrap");

    property p_tick_due;
        @(posedge clk) disable iff (!rstn)
        st.tick_cnt == sdr_pkg::SERVO_CNT_LAST
        |=> st.tick;
    endproperty
    a_tick_due: assert property (p_tick_due) else $error("servo tick missed");

    property p_tick_quiet;
        @(posedge clk) disable iff (!rstn)
        st.tick_cnt != sdr_pkg::SERVO_CNT_LAST
        |=> !st.tick;
    endproperty
    a_tick_quiet: assert property (p_tick_quiet) else $error("stray servo tick");

    property p_cnt_step;
        @(posedge clk) disable iff (!rstn)
        st.tick_cnt != sdr_pkg::SERVO_CNT_LAST
        |=> st.tick_cnt == 14'($past(st.tick_cnt) + 14'h0001);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("timebase skipped");

    property p_snap_stat3;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_stat3 == {16'h0000, $past(live.third_status_word)};
    endproperty
    a_snap_stat3: assert property (p_snap_stat3) else $error("status snapshot wrong");

    property p_snap_motion;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_tacc == $past(live.tacc) && st.snap_tvel == $past(live.tvel);
    endproperty
    a_snap_motion: assert property (p_snap_motion) else $error("target snapshot wrong");

    property p_snap_dir_io;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_dir_io == {$past(live.dir_mask), $past(live.io_state_word)};
    endproperty
    a_snap_dir_io: assert property (p_snap_dir_io) else $error("mask snapshot wrong");

    property p_snap_pbuf;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_pbuf == {$past(live.pbuf_size), $past(live.pbuf_start)};
    endproperty
    a_snap_pbuf: assert property (p_snap_pbuf) else $error("buffer snapshot wrong");

    property p_snap_an12;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_an12 == {$past(live.an1), $past(live.an2)};
    endproperty
    a_snap_an12: assert property (p_snap_an12) else $error("analog 1/2 wrong");

    property p_snap_an34;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_an34 == {$past(live.an3), $past(live.an4)};
    endproperty
    a_snap_an34: assert property (p_snap_an34) else $error("analog 3/4 wrong");

    property p_snap_drv_v;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_drv_v == {$past(live.drv_volt), $past(live.cpu_temp)};
    endproperty
    a_snap_drv_v: assert property (p_snap_drv_v) else $error("drive voltage wrong");

    property p_snap_cpu_v;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_cpu_v == {$past(live.cpu_volt), $past(live.drv_temp)};
    endproperty
    a_snap_cpu_v: assert property (p_snap_cpu_v) else $error("cpu voltage wrong");

    property p_snap_peak_v;
        @(posedge clk) disable iff (!rstn)
        st.tick
        |=> st.snap_peak_v == {$past(live.peak_volt), $past(live.drv_cal)};
    endproperty
    a_snap_peak_v: assert property (p_snap_peak_v) else $error("peak voltage wrong");

    property p_snap_hold;
        @(posedge clk) disable iff (!rstn)
        !st.tick
        |=> $stable(st.snap_stat3) && $stable(st.snap_tacc) && $stable(st.snap_tvel)
            && $stable(st.snap_dir_io) && $stable(st.snap_pbuf);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("read-only word changed");

    property p_analog_hold;
        @(posedge clk) disable iff (!rstn)
        !st.tick
        |=> $stable(st.snap_an12) && $stable(st.snap_an34) && $stable(st.snap_drv_v)
            && $stable(st.snap_cpu_v) && $stable(st.snap_peak_v);
    endproperty
    a_analog_hold: assert property (p_analog_hold) else $error("analog word changed");

    property p_enc_refresh;
        @(posedge clk) disable iff (!rstn)
        (st.tick && !wr_enc)
        |=> ext_enc_count == $past(live.ext_enc);
    endproperty
    a_enc_refresh: assert property (p_enc_refresh) else $error("encoder not refreshed");

    property p_enc_write;
        @(posedge clk) disable iff (!rstn)
        (wr_enc && req.half_en == sdr_pkg::HALF_BOTH)
        |=> ext_enc_count == $past(req.wdata);
    endproperty
    a_enc_write: assert property (p_enc_write) else $error("encoder write lost");

    property p_enc_hold;
        @(posedge clk) disable iff (!rstn)
        (!st.tick && !wr_enc)
        |=> $stable(ext_enc_count);
    endproperty
    a_enc_hold: assert property (p_enc_hold) else $error("encoder changed");

    property p_idx_hold;
        @(posedge clk) disable iff (!rstn)
        (!live.idx_trig && !wr_idx)
        |=> $stable(st.idx);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("index capture changed");

    property p_ol_write;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == sdr_pkg::REG_OL_TQ && req.half_en == sdr_pkg::HALF_BOTH)
        |=> open_loop_torque == $past(req.wdata);
    endproperty
    a_ol_write: assert property (p_ol_write) else $error("open-loop write lost");

    property p_cl_upper_keep;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == sdr_pkg::REG_CL_TQ && req.half_en == 2'h1)
        |=> closed_loop_torque[31:16] == $past(closed_loop_torque[31:16]);
    endproperty
    a_cl_upper_keep: assert property (p_cl_upper_keep) else $error("upper half disturbed");

    property p_err_upper_write;
        @(posedge clk) disable iff (!rstn)
        (req.wr && req.addr == sdr_pkg::REG_ERRLIM && req.half_en[1])
        |=> error_limits[31:16] == $past(req.wdata[31:16]);
    endproperty
    a_err_upper_write: assert property (p_err_upper_write) else $error("limit write lost");

    property p_limits_hold;
        @(posedge clk) disable iff (!rstn)
        !req.wr
        |=> $stable(closed_loop_torque) && $stable(open_loop_torque) && $stable(error_limits);
    endproperty
    a_limits_hold: assert property (p_limits_hold) else $error("limit changed");

    property p_rd_answer;
        @(posedge clk) disable iff (!rstn)
        req.rd
        |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

endmodule

// File: sdr_pkg.sv
/*
 * Package for the high dedicated data register bank: register numbers,
 * half-word layout, reset values and the servo cycle timing.
 * Assumes a single 100 MHz clock and that register numbers are word indexes.
 */
package sdr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SERVO_CYCLE_US = 120;
    localparam int unsigned SERVO_CYCLE_CYC = SERVO_CYCLE_US * 1000 / CLK_PERIOD_NS;
    localparam logic [13:0] SERVO_CNT_LAST = 14'(SERVO_CYCLE_CYC - 1);

    localparam logic [7:0] REG_EXT_ENC = 8'hC8;
    localparam logic [7:0] REG_EXT_IDX = 8'hC9;
    localparam logic [7:0] REG_RSVD_A  = 8'hCA;
    localparam logic [7:0] REG_STAT3   = 8'hCB;
    localparam logic [7:0] REG_TACC    = 8'hCC;
    localparam logic [7:0] REG_TVEL    = 8'hCD;
    localparam logic [7:0] REG_CL_TQ   = 8'hCE;
    localparam logic [7:0] REG_OL_TQ   = 8'hCF;
    localparam logic [7:0] REG_ERRLIM  = 8'hD0;
    localparam logic [7:0] REG_DIR_IO  = 8'hD1;
    localparam logic [7:0] REG_PBUF    = 8'hD2;
    localparam logic [7:0] REG_KILL    = 8'hD3;
    localparam logic [7:0] REG_AN12    = 8'hD4;
    localparam logic [7:0] REG_AN34    = 8'hD5;
    localparam logic [7:0] REG_DRV_V   = 8'hD6;
    localparam logic [7:0] REG_CPU_V   = 8'hD7;
    localparam logic [7:0] REG_PEAK_V  = 8'hD8;

    localparam int unsigned UPPER_LSB = 16;
    localparam int unsigned LOWER_MSB = 15;

    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [1:0]  HALF_BOTH  = 2'h3;

    // Host access: half_en[1] selects upper_half, half_en[0] lower_half
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [1:0]  half_en;
        logic [31:0] wdata;
    } sdr_req_t;

    // Live values presented by the servo core
    typedef struct packed {
        logic [31:0] ext_enc;
        logic        idx_trig;
        logic [15:0] third_status_word;
        logic [31:0] tacc;
        logic [31:0] tvel;
        logic [15:0] dir_mask;
        logic [15:0] io_state_word;
        logic [15:0] pbuf_size;
        logic [15:0] pbuf_start;
        logic        kill_evt;
        logic [15:0] kill_cond;
        logic [15:0] kill_state;
        logic [15:0] an1;
        logic [15:0] an2;
        logic [15:0] an3;
        logic [15:0] an4;
        logic [15:0] drv_volt;
        logic [15:0] cpu_temp;
        logic [15:0] cpu_volt;
        logic [15:0] drv_temp;
        logic [15:0] peak_volt;
        logic [15:0] drv_cal;
    } sdr_live_t;

    typedef struct packed {
        logic [13:0] tick_cnt;
        logic        tick;
        logic [31:0] enc;
        logic [31:0] idx;
        logic [31:0] cl_tq;
        logic [31:0] ol_tq;
        logic [31:0] errlim;
        logic [31:0] kill;
        logic [31:0] snap_stat3;
        logic [31:0] snap_tacc;
        logic [31:0] snap_tvel;
        logic [31:0] snap_dir_io;
        logic [31:0] snap_pbuf;
        logic [31:0] snap_an12;
        logic [31:0] snap_an34;
        logic [31:0] snap_drv_v;
        logic [31:0] snap_cpu_v;
        logic [31:0] snap_peak_v;
        logic        rvalid;
        logic [31:0] rdata;
    } sdr_state_t;

endpackage

// File: sdr_host.sv
/*
 * Host side model: issues one-cycle register requests to the bank.
 * Assumes the bank answers a read with rvalid within three cycles.
 */
module sdr_host (
    input  wire logic         clk,
    input  wire logic         rvalid,
    input  wire logic [31:0]  rdata,
    output sdr_pkg::sdr_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] h, output logic [31:0] q);
        logic got;
        got = 1'b0;
        q = 'x;
        @(negedge clk);
        req <= '{wr: w, rd: !w, addr: a, half_en: h, wdata: d};
        @(negedge clk);
        // Released lines flip so a stale value never looks valid
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, half_en: ~h, wdata: ~d};
        for (int n = 0; n < 3; n++) begin
            if (n > 0) @(negedge clk);
            if (rvalid === 1'b1 && !got) begin
                q = rdata;
                got = 1'b1;
            end
        end
    endtask
endmodule

// File: sdr_tb.sv
/*
 * Self-checking bench for the high data register bank.
 * Assumes the host model drives requests and the bench drives live values.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    sdr_pkg::sdr_req_t  req;
    sdr_pkg::sdr_live_t live;
    logic               rvalid;
    logic               servo_tick;
    logic [31:0]        rdata, enc_o, cl_o, ol_o, el_o, kill_o, q, old;
    logic [31:0]        exp_w [11];
    logic [7:0]         snap_a [11] = '{8'hC8, 8'hCB, 8'hCC, 8'hCD, 8'hD1, 8'hD2,
                                        8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8};
    logic [7:0]         rw_a [6] = '{8'hC8, 8'hC9, 8'hCE, 8'hCF, 8'hD0, 8'hD3};
    int                 errors = 0;
    int                 n_compared = 0;
    int                 cyc = 0;
    int                 t0, t1;

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    sdr_bank dut (.clk(clk), .rstn(rstn), .req(req), .live(live), .rvalid(rvalid),
        .rdata(rdata), .ext_enc_count(enc_o), .closed_loop_torque(cl_o),
        .open_loop_torque(ol_o), .error_limits(el_o), .kill_cause(kill_o),
        .servo_tick(servo_tick));
    sdr_host host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Distinct halves in every live field; pulses kept low
    task automatic fill(input int s);
        live = '0;
        for (int i = 0; i < 23; i++) live[i*16 +: 16] = 16'(16'h1357 * (i + s) + 16'h0A0B);
        live.idx_trig = 1'b0;
        live.kill_evt = 1'b0;
        exp_w = '{live.ext_enc, {16'h0000, live.third_status_word}, live.tacc, live.tvel,
            {live.dir_mask, live.io_state_word}, {live.pbuf_size, live.pbuf_start},
            {live.an1, live.an2}, {live.an3, live.an4}, {live.drv_volt, live.cpu_temp},
            {live.cpu_volt, live.drv_temp}, {live.peak_volt, live.drv_cal}};
    endtask

    task automatic wait_tick(output int t);
        for (int n = 0; n < 13000 && servo_tick !== 1'b1; n++) @(negedge clk);
        t = cyc;
    endtask

    function automatic logic [31:0] rw_exp(input int i);
        logic [1:0] h;
        h = 2'(i % 3 + 1);
        return {h[1] ? 16'h1234 : 16'hF0F0, h[0] ? 16'h5678 : 16'h0F0F};
    endfunction

    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    initial begin
        fill(0);
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        chk(enc_o | cl_o | ol_o | el_o | kill_o | 32'(rvalid), '0);
        $display("test reset done");

        foreach (rw_a[i]) begin
            host.xfer(1'b1, rw_a[i], 32'hF0F0_0F0F, 2'h3, q);
            host.xfer(1'b1, rw_a[i], 32'h1234_5678, 2'(i % 3 + 1), q);
            host.xfer(1'b0, rw_a[i], '0, 2'h0, q);
            chk(q, rw_exp(i));
        end
        chk(enc_o, rw_exp(0));
        chk(cl_o, rw_exp(2));
        chk(ol_o, rw_exp(3));
        chk(el_o, rw_exp(4));
        host.xfer(1'b0, 8'hC7, '0, 2'h0, q);
        chk(q, '0);
        host.xfer(1'b1, 8'hD9, 32'hFFFF_FFFF, 2'h3, q);
        host.xfer(1'b0, 8'hD9, '0, 2'h0, q);
        chk(q, '0);
        $display("test read_write done");

        live.ext_enc = 32'hCAFE_1234;
        live.idx_trig = 1'b1;
        @(negedge clk);
        live.idx_trig = 1'b0;
        live.ext_enc = 32'h0BAD_0BAD;
        host.xfer(1'b0, 8'hC9, '0, 2'h0, q);
        chk(q, 32'hCAFE_1234);
        live.kill_cond = 16'hC3A5;
        live.kill_state = 16'h5A3C;
        live.kill_evt = 1'b1;
        @(negedge clk);
        live.kill_evt = 1'b0;
        live.kill_cond = 16'h0000;
        host.xfer(1'b0, 8'hD3, '0, 2'h0, q);
        chk(q, 32'hC3A5_5A3C);
        chk(kill_o, 32'hC3A5_5A3C);
        host.xfer(1'b1, 8'hD3, 32'h0000_0000, 2'h3, q);
        host.xfer(1'b0, 8'hD3, '0, 2'h0, q);
        chk(q, '0);
        fork
            host.xfer(1'b1, 8'hD3, 32'h0000_0000, 2'h3, q);
            begin
                @(negedge clk);
                live.kill_cond = 16'h9669;
                live.kill_state = 16'h0FF0;
                live.kill_evt = 1'b1;
                @(negedge clk);
                live.kill_evt = 1'b0;
            end
        join
        host.xfer(1'b0, 8'hD3, '0, 2'h0, q);
        chk(q, 32'h9669_0FF0);
        $display("test index_kill done");

        for (int p = 0; p < 2; p++) begin
            old = p ? exp_w[6] : '0;
            fill(p + 1);
            host.xfer(1'b0, 8'hD4, '0, 2'h0, q);
            chk(q, old);
            wait_tick(t1);
            if (p) chk(32'(t1 - t0), 32'(sdr_pkg::SERVO_CYCLE_CYC));
            t0 = t1;
            repeat (2) @(negedge clk);
            foreach (snap_a[i]) begin
                if (i > 0) host.xfer(1'b1, snap_a[i], ~exp_w[i], 2'h3, q);
                host.xfer(1'b0, snap_a[i], '0, 2'h0, q);
                chk(q, exp_w[i]);
            end
            chk(enc_o, live.ext_enc);
        end
        $display("test snapshot done");
        end_of_test();
    end
endmodule
